// [hw/pfcu_phy_function_control_upper.sv]
// Purpose: Upper half of the per-port PHY function control register, APB slave.
// Assumes: Pause, duplex, self-test and indicator inputs share pclk; strap is a pin.
// Notes:   Interrupt status clears on read; a set in the same cycle wins.
//
// Functional notes
// - Bit 15 loads from the strap after reset, is writable, and enables auto crossover.
// - Bit 14 resets to 0 and when set forces the pairs into the crossed arrangement.
// - Read-only bit 13 resets to 0 and reports the resolved pause receive enable.
// - Read-only bit 12 resets to 0 and reports the resolved pause transmit enable.
// - Pause results follow the standard resolution table and only for full duplex.
// - Writing 1 to bit 11 injects exactly one self-test error, then the bit clears.
// - Bit 8 runs the self-test, bit 10 picks the long sequence, bit 9 reports pass or fail.
// - Self-test errors are counted outside this register, fed by an error pulse.
// - Bit 7 resets to 0 and when set makes each indicator follow its raw signal.

`timescale 1ns/100ps

module pfcu_phy_function_control_upper #(
  parameter int unsigned STRETCH_LEN = pfcu_pkg::STRETCH_CYCLES
) (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [pfcu_pkg::ADDR_W-1:0] paddr,
  input  wire logic [pfcu_pkg::DATA_W-1:0] pwdata,
  output logic      [pfcu_pkg::DATA_W-1:0] prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Strap pin
  input  wire logic                        strap_crossover_auto,
  // Auto-negotiation results
  input  wire logic [1:0]                  local_ability_advert,
  input  wire logic [1:0]                  partner_ability_register,
  input  wire logic                        hcd_valid,
  input  wire logic                        hcd_full_duplex,
  // Self-test checker
  input  wire logic                        selftest_error_detect,
  // Indicators
  input  wire logic [pfcu_pkg::LED_N-1:0]  indicator_raw,
  output logic      [pfcu_pkg::LED_N-1:0]  indicator_out,
  // Controls to the PHY
  output logic                             crossover_auto_enable,
  output logic                             crossover_force,
  output logic                             pause_rx_enable,
  output logic                             pause_tx_enable,
  output logic                             selftest_run,
  output logic                             long_sequence_select,
  output logic                             selftest_error_inject,
  output logic                             selftest_error_count_pulse,
  output logic                             indicator_stretch_bypass,
  // Interrupt
  output logic                             irq
);
  import pfcu_pkg::*;

  localparam logic [STRETCH_CNT_W-1:0] STRETCH_LOAD = STRETCH_CNT_W'(STRETCH_LEN);

  function automatic logic bus_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    bus_hit = (a == r);
  endfunction

  // ==========================================================================
  // APB decode
  wire logic setup_ph   = psel & ~penable;
  wire logic access_ph  = psel & penable;
  wire logic hit_pfc    = bus_hit(paddr, PFC_ADDR);
  wire logic hit_status = bus_hit(paddr, IRQ_STATUS_ADDR);
  wire logic hit_mask   = bus_hit(paddr, IRQ_MASK_ADDR);
  wire logic mapped     = hit_pfc | hit_status | hit_mask;
  wire logic wr_pfc     = access_ph & pwrite & hit_pfc;
  wire logic wr_mask    = access_ph & pwrite & hit_mask;
  wire logic rd_status  = access_ph & ~pwrite & hit_status;

  // Zero wait states: every access finishes in its first access cycle.
  assign pready  = 1'b1;
  assign pslverr = access_ph & ~mapped;

  // ==========================================================================
  // Strap synchroniser and capture
  logic           strap_s1_q;
  logic           strap_s2_q;
  logic [1:0]     settle_q;
  pfcu_strap_st_t strap_st_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
    end else begin
      strap_s1_q <= strap_crossover_auto;
      strap_s2_q <= strap_s1_q;
    end
  end

  // The strap is sampled only once the synchroniser has filled after release.
  wire logic strap_load = (strap_st_q == PFCU_STRAP_WAIT) && (settle_q == STRAP_SETTLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_q   <= 2'h0;
      strap_st_q <= PFCU_STRAP_WAIT;
    end else begin
      unique case (strap_st_q)
        PFCU_STRAP_WAIT: begin
          settle_q <= settle_q + 2'h1;
          if (strap_load) begin
            strap_st_q <= PFCU_STRAP_DONE;
          end
        end
        PFCU_STRAP_DONE: begin
          settle_q <= settle_q;
        end
      endcase
    end
  end

  // ==========================================================================
  // Writable control bits
  logic xauto_q, xforce_q, inject_q, seq_q, run_q, bypass_q;
  logic fail_q, prx_q, ptx_q;

  wire logic [REG_W-1:0] wdat = pwdata[REG_W-1:0] & PFC_WRITE_MASK;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xauto_q  <= PFC_RESET[BIT_XAUTO];
      xforce_q <= PFC_RESET[BIT_XFORCE];
      seq_q    <= PFC_RESET[BIT_SEQ];
      run_q    <= PFC_RESET[BIT_RUN];
      bypass_q <= PFC_RESET[BIT_BYP];
    end else if (wr_pfc) begin
      xauto_q  <= wdat[BIT_XAUTO];
      xforce_q <= wdat[BIT_XFORCE];
      seq_q    <= wdat[BIT_SEQ];
      run_q    <= wdat[BIT_RUN];
      bypass_q <= wdat[BIT_BYP];
    end else if (strap_load) begin
      xauto_q  <= strap_s2_q;
    end
  end

  // The inject bit lives exactly one cycle, which is the single error request.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inject_q <= PFC_RESET[BIT_INJ];
    end else begin
      inject_q <= wr_pfc & wdat[BIT_INJ];
    end
  end

  // ==========================================================================
  // Self-test result and error forwarding
  wire logic fail_d = run_q & (fail_q | selftest_error_detect);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_q                     <= 1'b0;
      selftest_error_count_pulse <= 1'b0;
    end else begin
      fail_q                     <= fail_d;
      selftest_error_count_pulse <= run_q & selftest_error_detect;
    end
  end

  wire logic result_bit = run_q & ~fail_q;

  // ==========================================================================
  // Pause resolution
  logic prx_c, ptx_c;

  pfcu_pause_resolve u_pause (
    .local_pause     (local_ability_advert),
    .partner_pause   (partner_ability_register),
    .hcd_valid       (hcd_valid),
    .hcd_full_duplex (hcd_full_duplex),
    .pause_rx        (prx_c),
    .pause_tx        (ptx_c)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prx_q <= PFC_RESET[BIT_PRX];
      ptx_q <= PFC_RESET[BIT_PTX];
    end else begin
      prx_q <= prx_c;
      ptx_q <= ptx_c;
    end
  end

  // ==========================================================================
  // Indicator pulse stretching
  logic [STRETCH_CNT_W-1:0] hold_q [LED_N];
  logic [LED_N-1:0]         led_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < LED_N; i++) begin
        hold_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < LED_N; i++) begin
        if (indicator_raw[i]) begin
          hold_q[i] <= STRETCH_LOAD;
        end else if (hold_q[i] != '0) begin
          hold_q[i] <= hold_q[i] - STRETCH_CNT_W'(1);
        end
      end
    end
  end

  logic [LED_N-1:0] stretched;
  always_comb begin
    stretched = '0;
    for (int i = 0; i < LED_N; i++) begin
      stretched[i] = indicator_raw[i] | (hold_q[i] != '0);
    end
  end

  // Registered so the pins see no glitch from the counter compare.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_q <= '0;
    end else begin
      led_q <= bypass_q ? indicator_raw : stretched;
    end
  end

  // ==========================================================================
  // Interrupt status and mask
  logic [IRQ_W-1:0] status_q, mask_q, shown_q;
  logic [IRQ_W-1:0] ev;

  always_comb begin
    ev = '0;
    ev[IRQ_SELFTEST_FAIL] = fail_d & ~fail_q;
    ev[IRQ_PAUSE_CHANGE]  = (prx_c != prx_q) | (ptx_c != ptx_q);
  end

  // Only the bits the reader actually saw are cleared; new events always win.
  wire logic [IRQ_W-1:0] status_d = (status_q & ~(rd_status ? shown_q : '0)) | ev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= IRQ_RESET;
      mask_q   <= IRQ_RESET;
    end else begin
      status_q <= status_d;
      if (wr_mask) begin
        mask_q <= pwdata[IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_d & mask_q);
    end
  end

  // ==========================================================================
  // Read data, captured in the setup cycle
  logic [REG_W-1:0] pfc_view;
  always_comb begin
    pfc_view             = '0;
    pfc_view[BIT_XAUTO]  = xauto_q;
    pfc_view[BIT_XFORCE] = xforce_q;
    pfc_view[BIT_PRX]    = prx_q;
    pfc_view[BIT_PTX]    = ptx_q;
    pfc_view[BIT_INJ]    = inject_q;
    pfc_view[BIT_SEQ]    = seq_q;
    pfc_view[BIT_RES]    = result_bit;
    pfc_view[BIT_RUN]    = run_q;
    pfc_view[BIT_BYP]    = bypass_q;
  end

  wire logic [DATA_W-1:0] rd_mux =
    hit_pfc    ? {{(DATA_W-REG_W){1'b0}}, pfc_view} :
    hit_status ? {{(DATA_W-IRQ_W){1'b0}}, status_q} :
    hit_mask   ? {{(DATA_W-IRQ_W){1'b0}}, mask_q}   : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      shown_q <= '0;
    end else if (setup_ph && !pwrite) begin
      prdata  <= rd_mux;
      shown_q <= hit_status ? status_q : '0;
    end
  end

  // ==========================================================================
  // Outputs
  assign crossover_auto_enable    = xauto_q;
  assign crossover_force          = xforce_q;
  assign pause_rx_enable          = prx_q;
  assign pause_tx_enable          = ptx_q;
  assign selftest_run             = run_q;
  assign long_sequence_select     = seq_q;
  assign selftest_error_inject    = inject_q;
  assign indicator_stretch_bypass = bypass_q;
  assign indicator_out            = led_q;

  // ==========================================================================
  // Checks
  chk_strap_loads_auto: assert property (@(posedge pclk) disable iff (!presetn)
    (strap_load && !wr_pfc) |=> (crossover_auto_enable == $past(strap_s2_q)))
    else $error("auto crossover did not take the strap value");

  chk_force_write_only: assert property (@(posedge pclk) disable iff (!presetn)
    (!wr_pfc) |=> $stable(crossover_force))
    else $error("force crossover changed without a write");

  chk_pause_rx_halfdup: assert property (@(posedge pclk) disable iff (!presetn)
    (!(hcd_valid && hcd_full_duplex)) |=> (!pause_rx_enable && !pause_tx_enable))
    else $error("pause resolved without full duplex");

  chk_pause_rx_table: assert property (@(posedge pclk) disable iff (!presetn)
    (hcd_valid && hcd_full_duplex && local_ability_advert[PAUSE_SYM]
     && partner_ability_register[PAUSE_SYM]) |=> (pause_rx_enable && pause_tx_enable))
    else $error("symmetric pause not resolved to both directions");

  chk_pause_tx_asym: assert property (@(posedge pclk) disable iff (!presetn)
    (hcd_valid && hcd_full_duplex && local_ability_advert == 2'h2
     && partner_ability_register == 2'h3) |=> (pause_tx_enable && !pause_rx_enable))
    else $error("asymmetric transmit pause not resolved");

  chk_inject_one_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    selftest_error_inject |=> !selftest_error_inject)
    else $error("error inject lasted more than one cycle");

  chk_inject_on_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_pfc && pwdata[BIT_INJ]) |=> selftest_error_inject)
    else $error("error inject did not follow the write");

  chk_fail_latched: assert property (@(posedge pclk) disable iff (!presetn)
    (run_q && selftest_error_detect && !wr_pfc) |=> (!result_bit) [*2])
    else $error("self-test failure not latched");

  chk_result_stopped: assert property (@(posedge pclk) disable iff (!presetn)
    (!selftest_run) |=> !fail_q)
    else $error("self-test fail latch kept while stopped");

  chk_count_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    (selftest_run && selftest_error_detect) |=> selftest_error_count_pulse)
    else $error("error count pulse missing");

  chk_bypass_follows: assert property (@(posedge pclk) disable iff (!presetn)
    indicator_stretch_bypass |=> (indicator_out == $past(indicator_raw)))
    else $error("indicator did not follow raw signal in bypass");

  chk_ro_bits_ignore: assert property (@(posedge pclk) disable iff (!presetn)
    wr_pfc |=> (pause_rx_enable == $past(prx_c) && pause_tx_enable == $past(ptx_c)))
    else $error("write reached a read-only pause bit");

  chk_irq_mask_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (mask_q == '0) |=> (mask_q == '0) |-> !irq)
    else $error("interrupt raised while fully masked");

endmodule

// [hw/pfcu_pkg.sv]
// Purpose: Shared constants for the PHY function control upper register block.
// Assumes: One 50 MHz clock; registers reached over APB with 32-bit data.
// Notes:   Register bits above the 16-bit register read as zero on the bus.

package pfcu_pkg;

  // ==========================================================================
  // Clock and bus shape
  localparam int unsigned CLK_FREQ_HZ = 50_000_000;
  localparam int          ADDR_W      = 12;
  localparam int          DATA_W      = 32;
  localparam int          REG_W       = 16;

  // ==========================================================================
  // Register map
  localparam logic [ADDR_W-1:0] PFC_INDEX       = 12'h019;
  localparam logic [ADDR_W-1:0] PFC_ADDR        = {PFC_INDEX[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 12'h080;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR   = 12'h084;

  // ==========================================================================
  // Field positions of the function control register
  localparam int BIT_XAUTO  = 15;
  localparam int BIT_XFORCE = 14;
  localparam int BIT_PRX    = 13;
  localparam int BIT_PTX    = 12;
  localparam int BIT_INJ    = 11;
  localparam int BIT_SEQ    = 10;
  localparam int BIT_RES    = 9;
  localparam int BIT_RUN    = 8;
  localparam int BIT_BYP    = 7;

  // Writable bits; everything else in the register ignores writes.
  localparam logic [REG_W-1:0] PFC_WRITE_MASK = 16'hcd80;
  localparam logic [REG_W-1:0] PFC_RESET      = 16'h0000;

  // ==========================================================================
  // Interrupt status and mask layout
  localparam int              IRQ_W            = 2;
  localparam int              IRQ_SELFTEST_FAIL = 0;
  localparam int              IRQ_PAUSE_CHANGE = 1;
  localparam logic [IRQ_W-1:0] IRQ_RESET       = 2'h0;

  // Pause advertisement field: symmetric pause and asymmetric direction.
  localparam int PAUSE_SYM  = 0;
  localparam int PAUSE_ASYM = 1;

  // ==========================================================================
  // Timing
  localparam int unsigned STRETCH_MS     = 50;
  localparam int unsigned STRETCH_CYCLES = (CLK_FREQ_HZ / 1000) * STRETCH_MS;
  localparam int          STRETCH_CNT_W  = 22;
  localparam int          LED_N          = 3;
  localparam logic [1:0]  STRAP_SETTLE   = 2'h2;

  typedef enum logic [0:0] {
    PFCU_STRAP_WAIT,
    PFCU_STRAP_DONE
  } pfcu_strap_st_t;

endpackage

// [hw/pfcu_pause_resolve.sv]
// Purpose: Pause resolution from local and partner pause advertisement.
// Assumes: Inputs come from logic on the same clock.
// Notes:   Purely combinational; the caller registers the results.

`timescale 1ns/100ps

module pfcu_pause_resolve (
  // Advertisement
  input  wire logic [1:0] local_pause,
  input  wire logic [1:0] partner_pause,
  // Resolved technology
  input  wire logic       hcd_valid,
  input  wire logic       hcd_full_duplex,
  // Results
  output logic            pause_rx,
  output logic            pause_tx
);
  import pfcu_pkg::*;

  // ==========================================================================
  // Resolution table
  wire logic l_sym  = local_pause[PAUSE_SYM];
  wire logic l_asym = local_pause[PAUSE_ASYM];
  wire logic p_sym  = partner_pause[PAUSE_SYM];
  wire logic p_asym = partner_pause[PAUSE_ASYM];
  wire logic fd_ok  = hcd_valid & hcd_full_duplex;

  // Half duplex never resolves pause, whatever both sides advertise.
  wire logic both_sym = l_sym & p_sym;
  wire logic rx_only  = l_sym & l_asym & ~p_sym & p_asym;
  wire logic tx_only  = ~l_sym & l_asym & p_sym & p_asym;

  assign pause_rx = fd_ok & (both_sym | rx_only);
  assign pause_tx = fd_ok & (both_sym | tx_only);

endmodule

// [testbench/pfcu_host_model.sv]
// Purpose: APB host model standing in for station management software.
// Assumes: One transfer at a time; the slave answers through pready.
// Notes:   Each wait for pready is bounded; a stuck slave bumps n_stall.

`timescale 1ns/100ps

module pfcu_host_model (
  // Clock
  input  wire logic                        pclk,
  // APB master side
  output logic                             psel,
  output logic                             penable,
  output logic                             pwrite,
  output logic      [pfcu_pkg::ADDR_W-1:0] paddr,
  output logic      [pfcu_pkg::DATA_W-1:0] pwdata,
  input  wire logic [pfcu_pkg::DATA_W-1:0] prdata,
  input  wire logic                        pready,
  input  wire logic                        pslverr
);
  import pfcu_pkg::*;

  int n_stall = 0;

  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
  end

  // ==========================================================================
  // One transfer: setup, then access held until pready is seen high.
  task automatic xfer(input logic [ADDR_W-1:0] a, input logic w, input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_stall++;
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Auto crossover is never left on while auto-negotiation is off.
  task automatic write_ctrl(input logic an_enabled, input logic [REG_W-1:0] v);
    logic [DATA_W-1:0] r;
    logic              e;
    xfer(PFC_ADDR, 1'b1, {16'h0000, v & {an_enabled, 15'h7fff}}, r, e);
  endtask
endmodule

// [testbench/test_phy_function_control_upper.sv]
// Purpose: Self-checking bench for the PHY function control upper block.
// Assumes: Stretch length shortened to 8 cycles; strap tied high.
// Notes:   Pause cases run from a table; the rest are hand-written.

`timescale 1ns/100ps

module test_phy_function_control_upper;
  import pfcu_pkg::*;

  localparam int unsigned SLEN = 8;

  logic                pclk = 1'b0;
  logic                presetn = 1'b0;
  logic                psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0]   paddr;
  logic [DATA_W-1:0]   pwdata, prdata, rd;
  logic                er, strap = 1'b1, hv = 1'b0, hfd = 1'b0, edet = 1'b0;
  logic [1:0]          ladv = 2'h0, padv = 2'h0;
  logic [LED_N-1:0]    raw = '0, led;
  logic                xa, xf, prx, ptx, run, lseq, inj, cntp, byp, irq;
  int                  n_fail = 0, check_count = 0, inj_seen = 0, err_seen = 0;
  // Rows: local[1:0], partner[1:0], valid, full duplex, rx, tx.
  logic [7:0]          rows [8] = '{8'b11_11_11_11, 8'b01_01_11_11, 8'b11_10_11_10,
                                    8'b10_11_11_01, 8'b11_11_10_00, 8'b11_11_01_00,
                                    8'b01_10_11_00, 8'b10_10_11_00};

  always #10 pclk = ~pclk;

  always @(posedge pclk) begin
    inj_seen <= inj_seen + (inj === 1'b1);
    err_seen <= err_seen + (cntp === 1'b1);
  end

  pfcu_phy_function_control_upper #(.STRETCH_LEN(SLEN)) i_pfcu_phy_function_control_upper (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .strap_crossover_auto(strap), .local_ability_advert(ladv),
    .partner_ability_register(padv), .hcd_valid(hv), .hcd_full_duplex(hfd),
    .selftest_error_detect(edet), .indicator_raw(raw), .indicator_out(led),
    .crossover_auto_enable(xa), .crossover_force(xf), .pause_rx_enable(prx),
    .pause_tx_enable(ptx), .selftest_run(run), .long_sequence_select(lseq),
    .selftest_error_inject(inj), .selftest_error_count_pulse(cntp),
    .indicator_stretch_bypass(byp), .irq(irq));

  pfcu_host_model i_pfcu_host_model (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ==========================================================================
  // Checking helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      $display("Error %0t: %s got %h expected %h", $time, m, got, exp);
      n_fail++;
    end
  endtask

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string m);
    i_pfcu_host_model.xfer(a, 1'b0, 32'h0000_0000, rd, er);
    chk(rd, exp, m);
  endtask

  task automatic err_pulse();
    @(posedge pclk);
    edet <= 1'b1;
    @(posedge pclk);
    edet <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic summarize();
    n_fail = n_fail + i_pfcu_host_model.n_stall;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge pclk);
    chk({xa, irq, pready}, 3'b001, "outputs in reset");
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    rdchk(PFC_ADDR, 32'h0000_8000, "reset value");
    chk({xa, xf, byp, run}, 4'b1000, "control outputs after reset");
    $display("Test reset done");

    foreach (rows[i]) begin
      @(posedge pclk);
      {ladv, padv, hv, hfd} <= rows[i][7:2];
      repeat (3) @(posedge pclk);
      chk({prx, ptx}, rows[i][1:0], "pause outputs");
      rdchk(PFC_ADDR, {16'h0, 1'b1, 1'b0, rows[i][1:0], 12'h000}, "pause bits");
    end
    $display("Test pause table done");

    i_pfcu_host_model.xfer(PFC_ADDR, 1'b1, 32'hffff_ffff, rd, er);
    rdchk(PFC_ADDR, 32'h0000_c780, "writable bits only");
    chk({xa, xf, run, lseq, byp}, 5'b11111, "control outputs set");
    chk(inj_seen, 1, "single inject pulse");
    $display("Test write all done");

    i_pfcu_host_model.xfer(IRQ_MASK_ADDR, 1'b1, 32'h0000_0001, rd, er);
    rdchk(IRQ_STATUS_ADDR, 32'h0000_0002, "pause change events");
    err_pulse();
    chk({irq, 31'(err_seen)}, {1'b1, 31'd1}, "irq and count pulse");
    rdchk(PFC_ADDR, 32'h0000_c580, "fail latched");
    rdchk(IRQ_STATUS_ADDR, 32'h0000_0001, "fail event");
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0, "irq cleared by read");
    i_pfcu_host_model.write_ctrl(1'b1, 16'hc480);
    rdchk(PFC_ADDR, 32'h0000_c480, "stopped reads zero");
    i_pfcu_host_model.write_ctrl(1'b1, 16'hc580);
    rdchk(PFC_ADDR, 32'h0000_c780, "restart clears latch");
    i_pfcu_host_model.xfer(IRQ_MASK_ADDR, 1'b1, 32'h0000_0000, rd, er);
    err_pulse();
    chk(irq, 1'b0, "masked irq");
    rdchk(IRQ_STATUS_ADDR, 32'h0000_0001, "sticky while masked");
    $display("Test self-test done");

    @(posedge pclk);
    raw <= 3'b101;
    repeat (2) @(posedge pclk);
    chk(led, 3'b101, "bypass follows raw");
    raw <= 3'b000;
    repeat (2) @(posedge pclk);
    chk(led, 3'b000, "bypass drops at once");
    i_pfcu_host_model.write_ctrl(1'b0, 16'h0000);
    @(posedge pclk);
    chk({xa, byp}, 2'b00, "auto crossover off");
    raw <= 3'b011;
    @(posedge pclk);
    raw <= 3'b000;
    repeat (4) @(posedge pclk);
    chk(led, 3'b011, "stretched");
    repeat (SLEN + 4) @(posedge pclk);
    chk(led, 3'b000, "stretch ends");
    $display("Test indicators done");

    i_pfcu_host_model.xfer(12'h0f0, 1'b1, 32'hffff_ffff, rd, er);
    chk(er, 1'b1, "unmapped write error");
    rdchk(12'h0f0, 32'h0000_0000, "unmapped read");
    chk(er, 1'b1, "unmapped read error");
    $display("Test unmapped done");
    summarize();
  end
endmodule
